// >>> shared/modbus_settings_update_bank_defines.vh
`ifndef MODBUS_SETTINGS_UPDATE_BANK_DEFINES_VH
`define MODBUS_SETTINGS_UPDATE_BANK_DEFINES_VH

`define CLK_HZ          25000000
`define REFRESH_MS      1000
`define ACTION_MS       100

`define FN_READ_HOLD    8'h03
`define FN_WRITE_ONE    8'h06
`define FN_WRITE_MULTI  8'h10
`define FN_MASK_WRITE   8'h16

`define EXC_BAD_FUNC    8'h01
`define EXC_BAD_ADDR    8'h02
`define EXC_BAD_VALUE   8'h03
`define EXC_REFUSED     8'h04
`define EXC_BUSY        8'h06

`define OFS_UNIT_SET    16'h0004
`define OFS_CONTROL     16'h0005
`define OFS_GENERAL     16'h0006
`define OFS_STATUS      16'h0007
`define OFS_TIME_LO     16'h0008
`define OFS_TIME_HI     16'h0009
`define OFS_BLK_TIME    16'h0064
`define OFS_BLK_TEMP    16'h0066
`define OFS_BLK_SNR     16'h0067
`define OFS_BLK_FLOW    16'h0068
`define OFS_BLK_TOTAL   16'h006a
`define OFS_UPD_FLAGS   16'h0088
`define OFS_DAMPING     16'h008a

`define BIT_HOLDOFF     0
`define BIT_PERSIST     3
`define BIT_REM_INH     1
`define BIT_TOT_INH     2
`define BIT_UPD_TOTAL   0
`define BIT_UPD_DAMP    4

`define UNIT_SET_BITS   5
`define UNIT_SET_COUNT  5'h04
`define UNITS_METRIC_A  2'h0
`define UNITS_IMPERIAL  2'h1
`define UNITS_US        2'h2
`define UNITS_METRIC_B  2'h3

`define YEAR_BASE       12'h7d0
`endif

// >>> verilog/modbus_settings_update_bank.v
`timescale 1ns/1ns
`include "modbus_settings_update_bank_defines.vh"

module modbus_settings_update_bank #(
	parameter REFRESH_CYCLES = `CLK_HZ / 1000 * `REFRESH_MS,
	parameter ACTION_CYCLES  = `CLK_HZ / 1000 * `ACTION_MS
) (
	input  wire        i_core_clk,
	input  wire        i_sys_rst,
	input  wire        i_req_valid,
	input  wire [7:0]  i_req_func,
	input  wire [15:0] i_req_addr,
	input  wire [15:0] i_req_count,
	input  wire [31:0] i_req_data,
	input  wire [15:0] i_req_and_mask,
	input  wire [15:0] i_req_or_mask,
	output reg         o_req_ready,
	output reg         o_rsp_valid,
	output reg  [15:0] o_rsp_data,
	output reg         o_rsp_last,
	output reg         o_rsp_exc,
	output reg  [7:0]  o_rsp_exc_code,
	input  wire        i_totals_inhibit,
	input  wire        i_remote_inhibit,
	input  wire        i_unit_restart,
	input  wire [5:0]  i_sec,
	input  wire [5:0]  i_min,
	input  wire [4:0]  i_hour,
	input  wire [4:0]  i_day,
	input  wire [3:0]  i_month,
	input  wire [11:0] i_year,
	input  wire [15:0] i_temp_x100,
	input  wire [15:0] i_snr_x100,
	input  wire [31:0] i_flow,
	input  wire [31:0] i_total,
	output reg  [1:0]  o_unit_set,
	output reg         o_total_load,
	output reg  [31:0] o_total_value,
	output reg         o_damping_load,
	output reg  [7:0]  o_damping_value
);

	localparam ST_IDLE = 2'h0;
	localparam ST_READ = 2'h1;
	localparam ST_BUSY = 2'h2;

	reg [1:0]  state_q;
	reg [15:0] rd_addr_q;
	reg [15:0] rd_left_q;
	reg [31:0] tick_q;
	reg        refresh_pend_q;
	reg [31:0] act_cnt_q;
	reg [15:0] unit_set_q;
	reg [15:0] control_q;
	reg [15:0] upd_flags_q;
	reg [15:0] damping_q;
	reg [1:0]  pend_q;
	reg [1:0]  act_q;
	reg [31:0] time_q;
	reg [15:0] temp_q, snr_q;
	reg [31:0] flow_q, total_q;
	reg [1:0]  tot_inh_s, rem_inh_s;
	reg [2:0]  restart_s;

	wire       tot_inh = tot_inh_s[1];
	wire       rem_inh = rem_inh_s[1];
	wire       holdoff = control_q[`BIT_HOLDOFF];
	wire [11:0] year_ofs = i_year - `YEAR_BASE;

	// Bit positions within the packed word follow seconds upward.
	wire [31:0] time_now = {year_ofs[5:0], i_month, i_day, i_hour,
		i_min, i_sec};

	function [15:0] rd_word;
		input [15:0] a;
		begin
			case (a)
			`OFS_UNIT_SET:  rd_word = unit_set_q;
			`OFS_CONTROL:   rd_word = control_q;
			`OFS_GENERAL:   rd_word = {14'h0000, rem_inh, 1'b0};
			`OFS_STATUS:    rd_word = {13'h0000, tot_inh, 2'h0};
			`OFS_TIME_LO, `OFS_BLK_TIME: rd_word = time_q[15:0];
			`OFS_TIME_HI, `OFS_BLK_TIME + 16'h0001: rd_word = time_q[31:16];
			`OFS_BLK_TEMP:  rd_word = temp_q;
			`OFS_BLK_SNR:   rd_word = snr_q;
			`OFS_BLK_FLOW:  rd_word = flow_q[31:16];
			`OFS_BLK_FLOW + 16'h0001: rd_word = flow_q[15:0];
			`OFS_BLK_TOTAL: rd_word = total_q[31:16];
			`OFS_BLK_TOTAL + 16'h0001: rd_word = total_q[15:0];
			`OFS_UPD_FLAGS: rd_word = upd_flags_q;
			`OFS_DAMPING:   rd_word = damping_q;
			default:        rd_word = 16'h0000;
			endcase
		end
	endfunction

	function mapped;
		input [15:0] a;
		begin
			mapped = (a >= `OFS_UNIT_SET && a <= `OFS_TIME_HI) ||
				(a >= `OFS_BLK_TIME && a <= `OFS_BLK_TOTAL + 16'h0001) ||
				a == `OFS_UPD_FLAGS || a == `OFS_DAMPING;
		end
	endfunction

	function is_total;
		input [15:0] a;
		begin
			is_total = a == `OFS_BLK_TOTAL ||
				a == `OFS_BLK_TOTAL + 16'h0001;
		end
	endfunction

	function writable;
		input [15:0] a;
		begin
			writable = a == `OFS_UNIT_SET || a == `OFS_CONTROL ||
				is_total(a) || a == `OFS_UPD_FLAGS ||
				a == `OFS_DAMPING;
		end
	endfunction

	// Selection and hold-off stay open so the master can recover control.
	function refused;
		input [15:0] a;
		input [15:0] v;
		begin
			refused = (rem_inh && (is_total(a) || a == `OFS_UPD_FLAGS ||
				a == `OFS_DAMPING)) ||
				(tot_inh && (is_total(a) || (a == `OFS_UPD_FLAGS &&
				v[`BIT_UPD_TOTAL])));
		end
	endfunction

	function [1:0] unit_fold;
		input [15:0] v;
		begin
			unit_fold = (v[`UNIT_SET_BITS-1:0] >= `UNIT_SET_COUNT) ?
				`UNITS_METRIC_A : v[1:0];
		end
	endfunction

	reg [15:0] w_addr, w_val0, w_val1, old0;
	reg        w_two;
	reg [7:0]  exc;
	reg        do_wr;

	always @* begin
		old0 = rd_word(i_req_addr);
		w_addr = i_req_addr;
		w_two = 1'b0;
		w_val0 = i_req_data[15:0];
		w_val1 = 16'h0000;
		exc = 8'h00;
		do_wr = 1'b0;
		case (i_req_func)
		`FN_READ_HOLD: begin
			if (i_req_count == 16'h0000 || !mapped(i_req_addr) ||
				!mapped(i_req_addr + i_req_count - 16'h0001)) begin
				exc = `EXC_BAD_ADDR;
			end
		end
		`FN_WRITE_ONE: do_wr = 1'b1;
		`FN_MASK_WRITE: begin
			do_wr = 1'b1;
			w_val0 = (old0 & i_req_and_mask) |
				(i_req_or_mask & ~i_req_and_mask);
		end
		`FN_WRITE_MULTI: begin
			do_wr = 1'b1;
			w_two = i_req_count == 16'h0002;
			w_val0 = w_two ? i_req_data[31:16] : i_req_data[15:0];
			w_val1 = i_req_data[15:0];
			if (i_req_count == 16'h0000 || i_req_count > 16'h0002) begin
				exc = `EXC_BAD_VALUE;
			end
		end
		default: exc = `EXC_BAD_FUNC;
		endcase
		if (do_wr && exc == 8'h00) begin
			if (!writable(w_addr) ||
				(w_two && w_addr != `OFS_BLK_TOTAL)) begin
				exc = `EXC_BAD_ADDR;
			end else if (refused(w_addr, w_val0) ||
				(w_two && refused(w_addr + 16'h0001, w_val1))) begin
				exc = `EXC_REFUSED;
			end
		end
		if (state_q == ST_BUSY) begin
			exc = `EXC_BUSY;
		end
	end

	wire take = i_req_valid && o_req_ready;
	wire wr_go = take && do_wr && exc == 8'h00;
	wire hit1 = wr_go && w_two;
	wire tick = tick_q == REFRESH_CYCLES - 1;
	wire can_refresh = state_q == ST_IDLE && !take && !holdoff;
	wire start_act = state_q == ST_IDLE && !take && !holdoff &&
		pend_q != 2'h0;

	// Performed actions are those not blocked at the moment they start.
	wire [1:0] blocked = {rem_inh, rem_inh | tot_inh};

	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			tot_inh_s <= 2'h0;
			rem_inh_s <= 2'h0;
			restart_s <= 3'h0;
			state_q <= ST_IDLE;
			rd_addr_q <= 16'h0000;
			rd_left_q <= 16'h0000;
			tick_q <= 32'h0;
			refresh_pend_q <= 1'b0;
			act_cnt_q <= 32'h0;
			unit_set_q <= 16'h0000;
			control_q <= 16'h0000;
			upd_flags_q <= 16'h0000;
			damping_q <= 16'h0000;
			pend_q <= 2'h0;
			act_q <= 2'h0;
			time_q <= 32'h0;
			temp_q <= 16'h0000;
			snr_q <= 16'h0000;
			flow_q <= 32'h0;
			total_q <= 32'h0;
			o_req_ready <= 1'b1;
			o_rsp_valid <= 1'b0;
			o_rsp_data <= 16'h0000;
			o_rsp_last <= 1'b0;
			o_rsp_exc <= 1'b0;
			o_rsp_exc_code <= 8'h00;
			o_unit_set <= `UNITS_METRIC_A;
			o_total_load <= 1'b0;
			o_total_value <= 32'h0;
			o_damping_load <= 1'b0;
			o_damping_value <= 8'h00;
		end else begin
			tot_inh_s <= {tot_inh_s[0], i_totals_inhibit};
			rem_inh_s <= {rem_inh_s[0], i_remote_inhibit};
			restart_s <= {restart_s[1:0], i_unit_restart};
			o_rsp_valid <= 1'b0;
			o_rsp_last <= 1'b0;
			o_rsp_exc <= 1'b0;
			o_total_load <= 1'b0;
			o_damping_load <= 1'b0;
			tick_q <= tick ? 32'h0 : tick_q + 32'h1;
			refresh_pend_q <= refresh_pend_q | tick;
			// The whole set, except a total held by its update flag, is copied in one cycle, never mid-read.
			if ((tick || refresh_pend_q) && can_refresh) begin
				refresh_pend_q <= 1'b0;
				time_q <= time_now;
				temp_q <= i_temp_x100;
				snr_q <= i_snr_x100;
				flow_q <= i_flow;
				// A pending or failed total keeps the written value.
				if (!upd_flags_q[`BIT_UPD_TOTAL]) begin
					total_q <= i_total;
				end
			end
			if (restart_s[1] && !restart_s[2] &&
				!control_q[`BIT_PERSIST]) begin
				unit_set_q <= 16'h0000;
				o_unit_set <= `UNITS_METRIC_A;
			end
			if (take) begin
				o_rsp_valid <= 1'b1;
				o_rsp_last <= 1'b1;
				if (exc != 8'h00) begin
					o_rsp_exc <= 1'b1;
					o_rsp_exc_code <= exc;
				end else if (i_req_func == `FN_READ_HOLD) begin
					o_rsp_data <= old0;
					o_rsp_last <= i_req_count == 16'h0001;
					if (i_req_count != 16'h0001) begin
						state_q <= ST_READ;
						o_req_ready <= 1'b0;
						rd_addr_q <= i_req_addr + 16'h0001;
						rd_left_q <= i_req_count - 16'h0002;
					end
				end else begin
					o_rsp_data <= w_val0;
				end
			end
			if (wr_go) begin
				case (w_addr)
				`OFS_UNIT_SET: begin
					unit_set_q <= {14'h0000, unit_fold(w_val0)};
					o_unit_set <= unit_fold(w_val0);
				end
				`OFS_CONTROL:   control_q <= w_val0;
				`OFS_UPD_FLAGS: begin
					upd_flags_q <= w_val0;
					pend_q <= pend_q | {w_val0[`BIT_UPD_DAMP] &
						~upd_flags_q[`BIT_UPD_DAMP],
						w_val0[`BIT_UPD_TOTAL] &
						~upd_flags_q[`BIT_UPD_TOTAL]};
				end
				`OFS_DAMPING:   damping_q <= w_val0;
				`OFS_BLK_TOTAL: total_q[31:16] <= w_val0;
				`OFS_BLK_TOTAL + 16'h0001: total_q[15:0] <= w_val0;
				default: ;
				endcase
				if (hit1) begin
					total_q[15:0] <= w_val1;
				end
			end
			case (state_q)
			ST_IDLE: begin
				if (start_act) begin
					state_q <= ST_BUSY;
					act_q <= pend_q & ~blocked;
					pend_q <= 2'h0;
					act_cnt_q <= 32'h0;
				end
			end
			ST_READ: begin
				o_rsp_valid <= 1'b1;
				o_rsp_data <= rd_word(rd_addr_q);
				rd_addr_q <= rd_addr_q + 16'h0001;
				rd_left_q <= rd_left_q - 16'h0001;
				if (rd_left_q == 16'h0000) begin
					o_rsp_last <= 1'b1;
					o_req_ready <= 1'b1;
					state_q <= ST_IDLE;
				end
			end
			ST_BUSY: begin
				act_cnt_q <= act_cnt_q + 32'h1;
				if (act_cnt_q == ACTION_CYCLES - 1) begin
					state_q <= ST_IDLE;
					o_total_load <= act_q[0];
					o_total_value <= total_q;
					o_damping_load <= act_q[1];
					o_damping_value <= damping_q[7:0];
					if (act_q[0]) upd_flags_q[`BIT_UPD_TOTAL] <= 1'b0;
					if (act_q[1]) upd_flags_q[`BIT_UPD_DAMP] <= 1'b0;
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

endmodule

// >>> tb/bank_chk.sv
`timescale 1ns/1ns
module bank_chk (
	input wire        i_core_clk,
	input wire        i_sys_rst,
	input wire        i_req_valid,
	input wire [7:0]  i_req_func,
	input wire [15:0] i_req_addr,
	input wire [15:0] i_req_count,
	input wire [31:0] i_req_data,
	input wire        o_req_ready,
	input wire        o_rsp_valid,
	input wire        o_rsp_last,
	input wire        o_rsp_exc,
	input wire [7:0]  o_rsp_exc_code,
	input wire [1:0]  o_unit_set,
	input wire        o_damping_load
);
	wire tk = i_req_valid && o_req_ready;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_rd2;
		tk && i_req_func == 8'h03 && i_req_count == 16'h0002;
	endsequence
	sequence s_two;
		o_rsp_valid && !o_rsp_last ##1 o_rsp_valid && o_rsp_last;
	endsequence
	sequence s_set;
		tk && i_req_func == 8'h06 && i_req_addr == 16'h0004;
	endsequence
	AST_ANSWER: assert property (tk |=> o_rsp_valid)
		else $error("request not answered");
	AST_TWO_WORDS: assert property (s_rd2 |=> o_rsp_exc or s_two)
		else $error("two word read not streamed");
	AST_STREAM: assert property (o_rsp_valid && !o_rsp_last |=> o_rsp_valid)
		else $error("gap in block answer");
	AST_HOLD: assert property (o_rsp_valid && !o_rsp_last |-> !o_req_ready)
		else $error("ready during block answer");
	AST_READY: assert property (o_rsp_valid && o_rsp_last |=> o_req_ready)
		else $error("ready not back after answer");
	AST_BAD_FUNC: assert property (tk && i_req_func == 8'h07 |=>
		o_rsp_exc && (o_rsp_exc_code == 8'h01 || o_rsp_exc_code == 8'h06))
		else $error("unknown function accepted");
	AST_EXC_WORD: assert property (o_rsp_exc |-> o_rsp_valid && o_rsp_last)
		else $error("exception not a single word");
	AST_UNIT_SET: assert property (s_set ##1 !o_rsp_exc |-> o_unit_set ==
		($past(i_req_data[4:0]) > 5'h03 ? 2'h0 : $past(i_req_data[1:0])))
		else $error("unit set selection wrong");
	AST_LOAD_PULSE: assert property (o_damping_load |=> !o_damping_load)
		else $error("damping load longer than a pulse");
endmodule
bind modbus_settings_update_bank bank_chk u_chk (.i_core_clk, .i_sys_rst,
	.i_req_valid, .i_req_func, .i_req_addr, .i_req_count, .i_req_data,
	.o_req_ready, .o_rsp_valid, .o_rsp_last, .o_rsp_exc, .o_rsp_exc_code,
	.o_unit_set, .o_damping_load);

// >>> tb/mb_master.sv
`timescale 1ns/1ns
module mb_master (
	input  wire        i_clk,
	input  wire        i_rdy,
	input  wire        i_vld,
	input  wire [15:0] i_dat,
	input  wire        i_last,
	input  wire        i_exc,
	input  wire [7:0]  i_code,
	output reg         o_valid,
	output reg  [7:0]  o_func,
	output reg  [15:0] o_addr,
	output reg  [15:0] o_count,
	output reg  [31:0] o_data,
	output reg  [15:0] o_and,
	output reg  [15:0] o_or
);
	reg [15:0] w [0:15];
	reg        ex;
	reg [7:0]  cd;
	reg        hung;
	integer    nw;
	initial begin
		{o_valid, o_func, o_addr, o_count, o_data, o_and, o_or} = 0;
	end
	// One request, held until taken, then the answer words are gathered.
	task xfer(input [7:0] f, input [15:0] a, input [15:0] n,
		input [31:0] d, input [15:0] am, input [15:0] om);
		integer t;
		begin
			@(posedge i_clk);
			o_valid <= 1'b1;
			o_func <= f;
			o_addr <= a;
			o_count <= n;
			o_data <= d;
			o_and <= am;
			o_or <= om;
			t = 0;
			@(posedge i_clk);
			while (!i_rdy && t < 50) begin
				@(posedge i_clk);
				t = t + 1;
			end
			// Released address and data lines show inverted values, not the stale request.
			o_valid <= 1'b0;
			o_addr <= ~a;
			o_data <= ~d;
			nw = 0;
			hung = 1'b1;
			for (t = 0; t < 40 && hung; t = t + 1) begin
				@(posedge i_clk);
				if (i_vld) begin
					w[nw] = i_dat;
					ex = i_exc;
					cd = i_code;
					nw = nw + 1;
					hung = !i_last;
				end
			end
		end
	endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench;
	reg clk = 0, rst = 1, ti = 0, ri = 0, ur = 0;
	reg [5:0] sec = 6'h2a, mnt = 6'h15;
	reg [4:0] hr = 5'h11, dy = 5'h1c;
	reg [3:0] mo = 4'h9;
	reg [11:0] yr = 12'd2037;
	reg [15:0] tp = 16'h0a6b, sn = 16'h14fa;
	reg [31:0] fl = 32'h3e80_0000, tot = 32'h4120_0000;
	wire v, rv, rl, re, rdy, tl, dl;
	wire [7:0] fn, cd, dv;
	wire [15:0] ad, cn, am, om, rd_d;
	wire [31:0] dt, tv;
	wire [1:0] us;
	integer err_count = 0, check_count = 0, dn = 0, tn = 0, k;
	reg [31:0] pk, e [0:7];
	reg [11:0] yd;
	always #20 clk = ~clk;
	always @(posedge clk) if (dl) dn <= dn + 1;
	always @(posedge clk) if (tl) tn <= tn + 1;
	modbus_settings_update_bank #(.REFRESH_CYCLES(50), .ACTION_CYCLES(8))
	u_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_req_valid(v),
		.i_req_func(fn), .i_req_addr(ad), .i_req_count(cn), .i_req_data(dt),
		.i_req_and_mask(am), .i_req_or_mask(om), .o_req_ready(rdy),
		.o_rsp_valid(rv), .o_rsp_data(rd_d), .o_rsp_last(rl), .o_rsp_exc(re),
		.o_rsp_exc_code(cd), .i_totals_inhibit(ti), .i_remote_inhibit(ri),
		.i_unit_restart(ur), .i_sec(sec), .i_min(mnt), .i_hour(hr),
		.i_day(dy), .i_month(mo), .i_year(yr), .i_temp_x100(tp),
		.i_snr_x100(sn), .i_flow(fl), .i_total(tot), .o_unit_set(us),
		.o_total_load(tl), .o_total_value(tv), .o_damping_load(dl),
		.o_damping_value(dv));
	mb_master u_m (.i_clk(clk), .i_rdy(rdy), .i_vld(rv), .i_dat(rd_d),
		.i_last(rl), .i_exc(re), .i_code(cd), .o_valid(v), .o_func(fn),
		.o_addr(ad), .o_count(cn), .o_data(dt), .o_and(am), .o_or(om));
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", check_count, err_count);
			if (err_count == 0 && check_count > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [31:0] x, input [31:0] g);
		begin
			check_count = check_count + 1;
			if (g !== x) begin
				err_count = err_count + 1;
				$display("[ERR] %0s exp %h got %h", nm, x, g);
			end
		end
	endtask
	task go(input [7:0] f, input [15:0] a, input [15:0] n, input [31:0] d,
		input [15:0] m, input [15:0] o);
		begin
			u_m.xfer(f, a, n, d, m, o);
			if (u_m.hung) begin
				err_count = err_count + 1;
				wrap_up;
			end
		end
	endtask
	task wt(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task t_set;
		begin
			for (k = 0; k < 10; k = k + 1) begin
				go(8'h06, 16'h4, 16'h1, 16'h0101 * k, 0, 0);
				e[0] = k > 3 ? 0 : k;
				chk("unitset", e[0], us);
				go(8'h03, 16'h4, 16'h1, 0, 0, 0);
				chk("readbk", e[0], u_m.w[0]);
			end
			go(8'h06, 16'h4, 16'h1, 16'h0022, 0, 0);
			chk("low5", 2, us);
			go(8'h16, 16'h4, 16'h1, 0, 16'hfffc, 16'h0003);
			chk("mask", 3, us);
			chk("noload", 0, dn);
			go(8'h07, 16'h4, 16'h1, 0, 0, 0);
			chk("badfn", 1, cd);
			go(8'h03, 16'h50, 16'h1, 0, 0, 0);
			chk("badadr", 2, cd);
			$display("unit set test done");
		end
	endtask
	task t_blk;
		begin
			yd = yr - 12'h7d0;
			pk = {yd[5:0], mo, dy, hr, mnt, sec};
			e[0] = pk[15:0]; e[1] = pk[31:16]; e[2] = tp; e[3] = sn;
			e[4] = fl[31:16]; e[5] = fl[15:0];
			e[6] = tot[31:16]; e[7] = tot[15:0];
			wt(60);
			go(8'h16, 16'h5, 16'h1, 0, 16'hfffe, 16'h1);
			fl <= 32'h4000_0000;
			wt(60);
			go(8'h03, 16'd100, 16'h8, 0, 0, 0);
			for (k = 0; k < 8; k = k + 1)
				chk("block", e[k], u_m.w[k]);
			chk("x100", 16'h0a6b, u_m.w[2]);
			go(8'h03, 16'd104, 16'h2, 0, 0, 0);
			chk("atomic", e[4], u_m.w[0]);
			go(8'h16, 16'h5, 16'h1, 0, 16'hfffe, 16'h0);
			wt(60);
			go(8'h03, 16'd104, 16'h2, 0, 0, 0);
			chk("fresh", 16'h4000, u_m.w[0]);
			$display("block read test done");
		end
	endtask
	task t_inh;
		begin
			ti <= 1;
			ri <= 1;
			wt(4);
			go(8'h03, 16'h6, 16'h1, 0, 0, 0);
			chk("remflag", 1, u_m.w[0][1]);
			go(8'h03, 16'h7, 16'h1, 0, 0, 0);
			chk("totflag", 1, u_m.w[0][2]);
			go(8'h06, 16'd138, 16'h1, 16'h5, 0, 0);
			chk("remref", 4, cd);
			ri <= 0;
			wt(4);
			go(8'h06, 16'd106, 16'h1, 0, 0, 0);
			chk("totref", 4, cd);
			chk("totexc", 1, u_m.ex);
			ti <= 0;
			$display("inhibit test done");
		end
	endtask
	task t_upd;
		begin
			go(8'h16, 16'h5, 16'h1, 0, 16'hfffe, 16'h1);
			go(8'h06, 16'd138, 16'h1, 16'h0094, 0, 0);
			go(8'h16, 16'd136, 16'h1, 0, 16'hffef, 16'h10);
			wt(40);
			chk("holdoff", 0, dn);
			go(8'h16, 16'h5, 16'h1, 0, 16'hfffe, 16'h0);
			go(8'h03, 16'd136, 16'h1, 0, 0, 0);
			chk("busy", 6, cd);
			wt(12);
			chk("applied", 8'h94, dv);
			go(8'h03, 16'd136, 16'h1, 0, 0, 0);
			chk("selfclr", 0, u_m.w[0][4]);
			go(8'h16, 16'h5, 16'h1, 0, 16'hfffe, 16'h1);
			go(8'h16, 16'd136, 16'h1, 0, 16'hffef, 16'h10);
			ri <= 1;
			wt(4);
			go(8'h16, 16'h5, 16'h1, 0, 16'hfffe, 16'h0);
			wt(20);
			ri <= 0;
			wt(4);
			go(8'h03, 16'd136, 16'h1, 0, 0, 0);
			chk("stays", 1, u_m.w[0][4]);
			go(8'h16, 16'd136, 16'h1, 0, 16'hffef, 16'h10);
			wt(20);
			chk("noedge", 1, dn);
			go(8'h03, 16'd138, 16'h1, 0, 0, 0);
			chk("kept", 16'h0094, u_m.w[0]);
			go(8'h16, 16'd136, 16'h1, 0, 16'hffef, 16'h0);
			wt(10);
			go(8'h16, 16'd136, 16'h1, 0, 16'hffef, 16'h10);
			wt(20);
			chk("retry", 2, dn);
			go(8'h16, 16'h5, 16'h1, 0, 16'hfffe, 16'h1);
			go(8'h10, 16'd106, 16'h2, 32'h4248_0000, 0, 0);
			chk("wrmul", 16'h4248, u_m.w[0]);
			go(8'h16, 16'd136, 16'h1, 0, 16'hfffe, 16'h1);
			wt(20);
			chk("totwait", 0, tn);
			go(8'h16, 16'h5, 16'h1, 0, 16'hfffe, 16'h0);
			wt(20);
			chk("totload", 1, tn);
			chk("totval", 32'h4248_0000, tv);
			go(8'h03, 16'd136, 16'h1, 0, 0, 0);
			chk("totclr", 0, u_m.w[0][0]);
			$display("update test done");
		end
	endtask
	task t_rst(input [15:0] p, input [1:0] x);
		begin
			go(8'h16, 16'h5, 16'h1, 0, 16'hfff7, p);
			go(8'h06, 16'h4, 16'h1, 16'h2, 0, 0);
			ur <= 1;
			wt(4);
			ur <= 0;
			wt(4);
			chk("persist", x, us);
			$display("restart test done");
		end
	endtask
	initial begin
		wt(8);
		rst <= 0;
		t_set;
		t_blk;
		t_inh;
		t_upd;
		t_rst(16'h0, 2'h0);
		t_rst(16'h8, 2'h2);
		wrap_up;
	end
endmodule
